//--- core/codec_serial_port.sv
// Host serial port of the codec with AXI4-Lite control registers.
// Assumes REF_CLK is the master clock; host follows our shift clock.
`timescale 1ns/10ps
module codec_serial_port (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [15:0] ADC_DATA,
    input wire logic ADC_VALID,
    output logic ADC_READY,
    output logic [15:0] DAC_DATA,
    output logic DAC_VALID,
    output logic SHIFT_CLOCK_OUT,
    output logic FRAME_SYNC_OUT,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OUT_OE_N,
    input wire logic SERIAL_DATA_IN,
    input wire logic MODE_SELECT,
    input wire logic FLASH_POWER_REQUEST_N,
    output logic FLASH_POWER_OUT,
    output codec_pkg::amp_ctrl_s AMP_CTRL
);
    import codec_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic aw_hold_q;
    logic w_hold_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic [4:0] ctrl_q;
    logic [15:0] frame_len_q;
    logic [15:0] eff_len;
    logic rx_flag_q;
    logic [15:0] rxdata_q;
    logic [2:0] pins_lvl;
    logic mode_high;
    logic flash_req_n;
    logic din_lvl;
    logic sclk_q;
    logic rise_stb;
    logic fall_stb;
    logic [15:0] period_q;
    frame_state_e state_q;
    logic fs_active;
    logic frame_start;
    logic [3:0] bit_q;
    logic [15:0] tx_q;
    logic [DIN_LAG-1:0] cap_q;
    logic [15:0] rx_q;
    logic [3:0] rx_cnt_q;
    logic rx_done;
    logic fifo_valid;
    logic [15:0] fifo_data;
    logic fifo_full;
    logic fifo_empty;
    logic [2:0] gain_code;

    assign mode_high = pins_lvl[0];
    assign flash_req_n = pins_lvl[1];
    assign din_lvl = pins_lvl[2];

    pin_sync #(.WIDTH(SYNC_STAGES), .RST_VAL(3'b010)) u_sync (
        .clk(REF_CLK),
        .srst(SRST),
        .pin_in({SERIAL_DATA_IN, FLASH_POWER_REQUEST_N, MODE_SELECT}),
        .level_out(pins_lvl)
    );

    sample_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(REF_CLK),
        .srst(SRST),
        .in_valid(ADC_VALID),
        .in_ready(ADC_READY),
        .in_data(ADC_DATA),
        .out_valid(fifo_valid),
        .out_ready(frame_start),
        .out_data(fifo_data),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // AXI write channels, taken in either order
    assign AWREADY = !aw_hold_q && !BVALID;
    assign WREADY = !w_hold_q && !BVALID;
    assign do_write = aw_hold_q && w_hold_q && !BVALID;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_hold_q <= 1'b1;
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (do_write) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_FRAME ||
                          awaddr_q == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
            end else if (BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // Control and frame period registers
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ctrl_q <= CTRL_RST;
            frame_len_q <= FRAME_LEN_RST;
        end else if (do_write && awaddr_q == ADDR_CTRL) begin
            ctrl_q <= 5'(merge({27'h0, ctrl_q}, wdata_q, wstrb_q));
        end else if (do_write && awaddr_q == ADDR_FRAME) begin
            frame_len_q <= 16'(merge({16'h0, frame_len_q}, wdata_q, wstrb_q));
        end
    end

    // Received-word flag: set wins over write-one clear
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rx_flag_q <= 1'b0;
        end else if (rx_done) begin
            rx_flag_q <= 1'b1;
        end else if (do_write && awaddr_q == ADDR_STATUS && wstrb_q[0] &&
                     wdata_q[STAT_RX_BIT]) begin
            rx_flag_q <= 1'b0;
        end
    end

    // AXI read channel
    assign ARREADY = !RVALID;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= RESP_OKAY;
            RDATA <= '0;
            unique case (ARADDR)
                ADDR_CTRL: RDATA <= {27'h0, ctrl_q};
                ADDR_FRAME: RDATA <= {16'h0, frame_len_q};
                ADDR_STATUS: RDATA <= {27'h0, fs_active, mode_high, fifo_full, fifo_empty,
                                       rx_flag_q};
                ADDR_RXDATA: RDATA <= {16'h0, rxdata_q};
                default: RRESP <= RESP_SLVERR;
            endcase
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    // Amplifier settings; codes above the mute code also mute
    assign gain_code = ctrl_q[CTRL_GAIN_LSB +: 3];
    assign AMP_CTRL.gain = gain_code[1:0];
    assign AMP_CTRL.buf_mute = gain_code >= GAIN_MUTE;
    assign AMP_CTRL.mon_mute = ctrl_q[CTRL_MON_MUTE_BIT];

    // Flash write power follows the filtered request
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            FLASH_POWER_OUT <= 1'b0;
        end else begin
            FLASH_POWER_OUT <= !flash_req_n;
        end
    end

    // Shift clock: master clock divided by two
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= !sclk_q;
        end
    end
    assign rise_stb = !sclk_q;
    assign fall_stb = sclk_q;
    assign SHIFT_CLOCK_OUT = sclk_q;

    // Sample period in shift clocks, never shorter than one word plus a gap
    assign eff_len = (frame_len_q < FRAME_LEN_MIN) ? FRAME_LEN_MIN : frame_len_q;

    always_ff @(posedge REF_CLK) begin
        if (SRST || !ctrl_q[CTRL_EN_BIT]) begin
            period_q <= '0;
        end else if (rise_stb) begin
            period_q <= (period_q >= eff_len - 16'd1) ? '0 : period_q + 16'd1;
        end
    end

    assign fs_active = state_q == ST_FRAME;
    assign frame_start = rise_stb && period_q == '0 && ctrl_q[CTRL_EN_BIT] &&
                         state_q == ST_GAP;

    // Frame: sixteen shift clocks, MSB first, bits change on rising edges
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_q <= ST_GAP;
            bit_q <= '0;
            tx_q <= '0;
        end else begin
            unique case (state_q)
                ST_GAP: begin
                    if (frame_start) begin
                        state_q <= ST_FRAME;
                        bit_q <= '0;
                        tx_q <= fifo_valid ? fifo_data : '0;
                    end
                end
                ST_FRAME: begin
                    if (rise_stb) begin
                        if (bit_q == LAST_BIT) begin
                            state_q <= ST_GAP;
                        end else begin
                            bit_q <= bit_q + 4'd1;
                            tx_q <= {tx_q[14:0], 1'b0};
                        end
                    end
                end
                default: state_q <= ST_GAP;
            endcase
        end
    end

    assign FRAME_SYNC_OUT = fs_active ^ !mode_high;
    assign SERIAL_DATA_OUT = tx_q[15];
    assign SERIAL_DATA_OUT_OE_N = !fs_active;

    // Input bits sampled at falling edges, read after synchroniser lag
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cap_q <= '0;
        end else begin
            cap_q <= {cap_q[DIN_LAG-2:0], fall_stb && fs_active};
        end
    end

    assign rx_done = cap_q[DIN_LAG-1] && rx_cnt_q == LAST_BIT;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rx_q <= '0;
            rx_cnt_q <= '0;
            rxdata_q <= '0;
            DAC_DATA <= '0;
            DAC_VALID <= 1'b0;
        end else begin
            DAC_VALID <= rx_done;
            if (cap_q[DIN_LAG-1]) begin
                rx_q <= {rx_q[14:0], din_lvl};
                rx_cnt_q <= rx_cnt_q + 4'd1;
            end
            if (rx_done) begin
                DAC_DATA <= {rx_q[14:0], din_lvl};
                rxdata_q <= {rx_q[14:0], din_lvl};
            end
        end
    end

    property p_sclk_div;
        @(posedge REF_CLK) disable iff (SRST) !$past(SRST) |-> SHIFT_CLOCK_OUT != $past(SHIFT_CLOCK_OUT);
    endproperty
    a_sclk_div: assert property (p_sclk_div) else $error("shift clock not half rate");

    property p_start_on_rise;
        @(posedge REF_CLK) disable iff (SRST) frame_start |=> SHIFT_CLOCK_OUT && fs_active;
    endproperty
    a_start_on_rise: assert property (p_start_on_rise) else $error("frame off clock");

    property p_tx_quiet;
        @(posedge REF_CLK) disable iff (SRST) !fs_active && !frame_start |=> $stable(tx_q);
    endproperty
    a_tx_quiet: assert property (p_tx_quiet) else $error("shift outside frame");

    property p_release;
        @(posedge REF_CLK) disable iff (SRST) !fs_active |-> SERIAL_DATA_OUT_OE_N;
    endproperty
    a_release: assert property (p_release) else $error("data driven outside frame");

    property p_pop;
        @(posedge REF_CLK) disable iff (SRST) frame_start && fifo_valid |=> tx_q == $past(fifo_data);
    endproperty
    a_pop: assert property (p_pop) else $error("frame word not loaded");

    property p_polarity;
        @(posedge REF_CLK) disable iff (SRST) fs_active |-> FRAME_SYNC_OUT == mode_high;
    endproperty
    a_polarity: assert property (p_polarity) else $error("frame polarity wrong");

    property p_gain;
        @(posedge REF_CLK) disable iff (SRST) do_write && awaddr_q == ADDR_CTRL && wstrb_q[0]
            |=> AMP_CTRL.buf_mute == ($past(wdata_q[3:1]) >= GAIN_MUTE);
    endproperty
    a_gain: assert property (p_gain) else $error("buffer mute wrong");

    property p_mon;
        @(posedge REF_CLK) disable iff (SRST) do_write && awaddr_q == ADDR_CTRL && wstrb_q[0]
            |=> AMP_CTRL.mon_mute == $past(wdata_q[CTRL_MON_MUTE_BIT]);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor mute wrong");

    property p_flash;
        @(posedge REF_CLK) disable iff (SRST) FLASH_POWER_REQUEST_N [*5] |-> ##1 !FLASH_POWER_OUT;
    endproperty
    a_flash: assert property (p_flash) else $error("flash power not off");

    property p_mode;
        @(posedge REF_CLK) disable iff (SRST) MODE_SELECT [*5] |-> ##1 mode_high;
    endproperty
    a_mode: assert property (p_mode) else $error("mode pin not followed");

    property p_reset;
        @(posedge REF_CLK) $past(SRST) |-> ctrl_q == CTRL_RST && !fs_active && !BVALID;
    endproperty
    a_reset: assert property (p_reset) else $error("reset defaults wrong");

    property p_word;
        @(posedge REF_CLK) disable iff (SRST) $rose(fs_active) |-> fs_active [*8] ##25 !fs_active;
    endproperty
    a_word: assert property (p_word) else $error("frame not sixteen bits");
endmodule // codec_serial_port

//--- core/codec_pkg.sv
// Constants, types and register map of the codec host serial port.
// Assumes a single 100 MHz master clock and AXI4-Lite register access.
// How it works
// - Shift clock is master clock divided by two
// - Every internal timing comes from master clock
// - Bits move only inside the frame interval
// - Data output released whenever frame is inactive
// - Frame sync held active for the whole of each frame
// - Frame sync polarity follows frame mode
// - Buffer gain 0/-6/-12/-18 dB or muted
// - Monitor amplifier unity gain or muted
// - Flash power on only while request low
// - Mode pin high selects high-active frame mode
// - Reset returns all registers to defaults
// - Every transfer carries one 16-bit word
package codec_pkg;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_FRAME = 32'h0000_0004;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
    localparam logic [31:0] ADDR_RXDATA = 32'h0000_000c;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_GAIN_LSB = 1;
    localparam int CTRL_MON_MUTE_BIT = 4;
    localparam logic [4:0] CTRL_RST = 5'h10;
    localparam int STAT_RX_BIT = 0;
    localparam int STAT_EMPTY_BIT = 1;
    localparam int STAT_FULL_BIT = 2;
    localparam int STAT_MODE_BIT = 3;
    localparam int STAT_FRAME_BIT = 4;
    localparam logic [2:0] GAIN_0DB = 3'h0;
    localparam logic [2:0] GAIN_M6DB = 3'h1;
    localparam logic [2:0] GAIN_M12DB = 3'h2;
    localparam logic [2:0] GAIN_M18DB = 3'h3;
    localparam logic [2:0] GAIN_MUTE = 3'h4;
    localparam int WORD_BITS = 16;
    localparam logic [3:0] LAST_BIT = 4'hf;
    localparam logic [15:0] FRAME_LEN_RST = 16'h0020;
    localparam logic [15:0] FRAME_LEN_MIN = 16'h0012;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_STAGES = 3;
    localparam int DIN_LAG = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [1:0] gain;
        logic buf_mute;
        logic mon_mute;
    } amp_ctrl_s;
    typedef enum logic [1:0] {
        ST_GAP = 2'b01,
        ST_FRAME = 2'b10
    } frame_state_e;
endpackage

//--- core/pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pins are asynchronous to clk.
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Level changes once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge clk) begin
                if (srst) begin
                    level_out[g] <= RST_VAL[g];
                end else if (s2_q[g] == s3_q[g]) begin
                    level_out[g] <= s3_q[g];
                end
            end
        end
    endgenerate
endmodule // pin_sync

//--- core/sample_fifo.sv
// Synchronous FIFO for ADC sample words.
// Assumes one clock and a synchronous reset.
`timescale 1ns/10ps
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic full,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] count_q;
    logic push;
    logic pop;

    assign full = count_q == CW'(DEPTH);
    assign empty = count_q == '0;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
endmodule // sample_fifo

//--- test/host_port_model.sv
// Host serial port model facing the codec's shift clock, frame sync and data pins.
// Assumes the device is timing master and mode follows the frame mode pin.
`timescale 1ns/10ps
module host_port_model (
    input wire logic clk,
    input wire logic sclk,
    input wire logic fs,
    input wire logic mode,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic [15:0] tx_word,
    output logic din,
    output logic [15:0] rx_word,
    output logic rx_done
);
    logic [15:0] tx_q = 16'h0;
    logic [4:0] tx_cnt = 5'h0;
    logic [4:0] rx_cnt = 5'h0;
    logic line_q = 1'b0;
    logic frame;
    assign frame = (fs === mode);
    initial begin
        din = 1'b0;
        rx_word = 16'h0;
        rx_done = 1'b0;
    end
    always @(posedge clk) begin
        #1;
        rx_done = 1'b0;
        // Released line floats: toggle so nothing stale is seen
        line_q = dout_oe_n ? ~line_q : dout;
        if (!frame) begin
            tx_cnt = 5'h0;
            rx_cnt = 5'h0;
            din = ~din;
        end else if (sclk) begin
            if (tx_cnt == 5'h0) tx_q = tx_word;
            if (tx_cnt < 5'h10) din = tx_q[4'hf - tx_cnt[3:0]];
            tx_cnt = tx_cnt + 5'h1;
        end else begin
            rx_word = {rx_word[14:0], line_q};
            rx_cnt = rx_cnt + 5'h1;
            if (rx_cnt == 5'h10) rx_done = 1'b1;
        end
    end
endmodule // host_port_model

//--- test/tb_top.sv
// Self-checking bench of the codec serial port: AXI4-Lite, ADC FIFO, serial link.
// Assumes the host port model on the far side and a 100 MHz master clock.
`timescale 1ns/10ps
module tb_top;
    import codec_pkg::*;
    logic REF_CLK = 1'b0;
    logic SRST = 1'b1;
    logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, ADC_READY, DAC_VALID;
    logic [1:0] BRESP, RRESP;
    logic [15:0] ADC_DATA = 16'h0, DAC_DATA, tx_word, rx_word, last_dac;
    logic ADC_VALID = 1'b0, MODE_SELECT = 1'b1, FLASH_POWER_REQUEST_N = 1'b1;
    logic SHIFT_CLOCK_OUT, FRAME_SYNC_OUT, SERIAL_DATA_OUT, SERIAL_DATA_OUT_OE_N;
    logic SERIAL_DATA_IN, FLASH_POWER_OUT, rx_done, sclk_prev = 1'b0, rst_prev = 1'b1;
    amp_ctrl_s AMP_CTRL;
    int err_count = 0;
    int samples_checked = 0;
    int mode_age = 0;
    int fs_len = 0;
    logic [33:0] rd_q[$];
    logic [1:0] b_q[$];
    logic [15:0] adc_q[$];
    logic [15:0] dac_q[$];

    always #5 REF_CLK = ~REF_CLK;

    codec_serial_port uut (.REF_CLK(REF_CLK), .SRST(SRST), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .ADC_DATA(ADC_DATA), .ADC_VALID(ADC_VALID), .ADC_READY(ADC_READY),
        .DAC_DATA(DAC_DATA), .DAC_VALID(DAC_VALID), .SHIFT_CLOCK_OUT(SHIFT_CLOCK_OUT),
        .FRAME_SYNC_OUT(FRAME_SYNC_OUT), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
        .SERIAL_DATA_OUT_OE_N(SERIAL_DATA_OUT_OE_N), .SERIAL_DATA_IN(SERIAL_DATA_IN),
        .MODE_SELECT(MODE_SELECT), .FLASH_POWER_REQUEST_N(FLASH_POWER_REQUEST_N),
        .FLASH_POWER_OUT(FLASH_POWER_OUT), .AMP_CTRL(AMP_CTRL));

    host_port_model host (.clk(REF_CLK), .sclk(SHIFT_CLOCK_OUT), .fs(FRAME_SYNC_OUT),
        .mode(MODE_SELECT), .dout(SERIAL_DATA_OUT), .dout_oe_n(SERIAL_DATA_OUT_OE_N),
        .tx_word(tx_word), .din(SERIAL_DATA_IN), .rx_word(rx_word), .rx_done(rx_done));

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [31:0] addr, input logic [31:0] data,
                             input logic [1:0] resp);
        logic a, w, done;
        b_q.push_back(resp);
        AWADDR <= addr;
        WDATA <= data;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(negedge REF_CLK);
            a = AWVALID && AWREADY;
            w = WVALID && WREADY;
            done = BVALID;
            @(posedge REF_CLK);
            if (a) AWVALID <= 1'b0;
            if (w) WVALID <= 1'b0;
        end while (!done);
        BREADY <= 1'b0;
        @(posedge REF_CLK);
    endtask

    task automatic axi_read(input logic [31:0] addr, input logic [31:0] data,
                            input logic [1:0] resp);
        logic a, done;
        rd_q.push_back({resp, data});
        ARADDR <= addr;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(negedge REF_CLK);
            a = ARVALID && ARREADY;
            done = RVALID;
            @(posedge REF_CLK);
            if (a) ARVALID <= 1'b0;
        end while (!done);
        RREADY <= 1'b0;
        @(posedge REF_CLK);
    endtask

    // Caller keeps lim within the free FIFO space, so every offer is taken
    task automatic adc_fill(input int lim);
        repeat (lim) begin
            ADC_DATA <= 16'($urandom);
            ADC_VALID <= 1'b1;
            @(posedge REF_CLK);
            adc_q.push_back(ADC_DATA);
        end
        ADC_VALID <= 1'b0;
        @(posedge REF_CLK);
    endtask

    task automatic reset_checks();
        check({AWREADY, WREADY, ARREADY, BVALID, RVALID}, 5'h1c);
        check({FLASH_POWER_OUT, DAC_VALID, AMP_CTRL}, 6'h01);
        axi_read(ADDR_CTRL, {27'h0, CTRL_RST}, RESP_OKAY);
        axi_read(ADDR_FRAME, {16'h0, FRAME_LEN_RST}, RESP_OKAY);
        axi_read(ADDR_STATUS, 32'h2 | (32'(MODE_SELECT) << 3), RESP_OKAY);
        axi_read(ADDR_RXDATA, 32'h0, RESP_OKAY);
    endtask

    task automatic run_frames(input int cycles);
        axi_write(ADDR_CTRL, 32'h1, RESP_OKAY);
        repeat (cycles) @(posedge REF_CLK);
        axi_write(ADDR_CTRL, 32'h0, RESP_OKAY);
        repeat (100) @(posedge REF_CLK);
    endtask

    // Comparators: oldest note against each result
    always @(posedge REF_CLK) begin
        if (BVALID && BREADY) check(BRESP, b_q.pop_front());
        if (RVALID && RREADY) check({RRESP, RDATA}, rd_q.pop_front());
        if (DAC_VALID) check(DAC_DATA, dac_q.pop_front());
    end

    always @(posedge rx_done) begin
        check(rx_word, adc_q.size() > 0 ? adc_q.pop_front() : 16'h0);
        dac_q.push_back(tx_word);
        last_dac = tx_word;
        tx_word = 16'($urandom);
    end

    // Wire monitor: clock rate, output enable and frame length
    always @(posedge REF_CLK) begin
        rst_prev <= SRST;
        sclk_prev <= SHIFT_CLOCK_OUT;
        mode_age <= SRST ? 0 : (mode_age < 99 ? mode_age + 1 : mode_age);
        if (!SRST && !rst_prev) check(SHIFT_CLOCK_OUT, !sclk_prev);
        if (mode_age > 8 && FRAME_SYNC_OUT === MODE_SELECT) begin
            fs_len <= fs_len + 1;
            check(SERIAL_DATA_OUT_OE_N, 1'b0);
        end else if (mode_age > 8) begin
            check(SERIAL_DATA_OUT_OE_N, 1'b1);
            if (fs_len != 0) check(fs_len, 32);
            fs_len <= 0;
        end
    end

    initial begin
        #500000;
        err_count++;
        complete_run();
    end

    initial begin
        int n;
        void'($urandom(32'hdc2d));
        tx_word = 16'($urandom);
        repeat (2) @(posedge REF_CLK);
        SRST <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        reset_checks();
        axi_read(32'h10, 32'h0, RESP_SLVERR);
        axi_write(ADDR_RXDATA, 32'h1234, RESP_SLVERR);
        for (int c = 0; c < 8; c++) begin
            n = $urandom_range(1);
            axi_write(ADDR_CTRL, 32'((c << 1) | (n << 4)), RESP_OKAY);
            check(AMP_CTRL, {c[1:0], c > 3, n[0]});
            axi_read(ADDR_CTRL, 32'((c << 1) | (n << 4)), RESP_OKAY);
        end
        repeat (6) begin
            FLASH_POWER_REQUEST_N <= 1'($urandom_range(1));
            repeat (8) @(posedge REF_CLK);
            check(FLASH_POWER_OUT, !FLASH_POWER_REQUEST_N);
        end
        FLASH_POWER_REQUEST_N <= 1'b1;
        adc_fill(16);
        check(ADC_READY, 1'b0);
        axi_read(ADDR_STATUS, 32'h4 | 32'h8, RESP_OKAY);
        axi_write(ADDR_FRAME, {16'h0, FRAME_LEN_MIN}, RESP_OKAY);
        run_frames(800);
        axi_read(ADDR_STATUS, 32'h3 | 32'h8, RESP_OKAY);
        axi_read(ADDR_RXDATA, {16'h0, last_dac}, RESP_OKAY);
        axi_write(ADDR_STATUS, 32'h1, RESP_OKAY);
        axi_read(ADDR_STATUS, 32'h2 | 32'h8, RESP_OKAY);
        SRST <= 1'b1;
        @(posedge REF_CLK);
        MODE_SELECT <= 1'b0;
        @(posedge REF_CLK);
        SRST <= 1'b0;
        repeat (8) @(posedge REF_CLK);
        reset_checks();
        adc_fill(3);
        run_frames(300);
        axi_read(ADDR_RXDATA, {16'h0, last_dac}, RESP_OKAY);
        complete_run();
    end
endmodule // tb_top
